// ### design/emr_defs.vh
// Constants for the energy monitor readout register bank
`ifndef EMR_DEFS_VH
`define EMR_DEFS_VH
// ****************************************************************
// Register offsets
// ****************************************************************
`define EMR_OFS_CONFIG      8'h11
`define EMR_OFS_SOURCE1_VOLTAGE_CODE_LOW    8'h19
`define EMR_OFS_SOURCE1_VOLTAGE_CODE_MID    8'h1A
`define EMR_OFS_SOURCE1_VOLTAGE_CODE_HIGH   8'h1B
`define EMR_OFS_SOURCE2_VOLTAGE_CODE_LOW    8'h1C
`define EMR_OFS_SOURCE2_VOLTAGE_CODE_MID    8'h1D
`define EMR_OFS_SOURCE2_VOLTAGE_CODE_HIGH   8'h1E
`define EMR_OFS_OUT_LOW     8'h1F
`define EMR_OFS_OUT_MID     8'h20
`define EMR_OFS_OUT_HIGH    8'h21
`define EMR_OFS_ERR_STATUS  8'h22
`define EMR_OFS_THERM       8'h23
`define EMR_OFS_STORAGE     8'h24
`define EMR_OFS_SOURCE1_VOLTAGE_CODE_CODE   8'h25
`define EMR_OFS_SOURCE2_VOLTAGE_CODE_CODE   8'h26
// ****************************************************************
// Fields and reset values
// ****************************************************************
`define EMR_CFG_WMASK       8'h1F
`define EMR_CFG_RESET       8'h00
`define EMR_RESULT_RESET    8'h00
`define EMR_ENERGY_W        23
`define EMR_CHANNELS        3
// ****************************************************************
// Source code segments
// ****************************************************************
`define EMR_SEG1_END        8'h06
`define EMR_SEG2_END        8'h12
`define EMR_SEG3_END        8'h39
`define EMR_SEG4_BEG        8'h68
`define EMR_SEG4_END        8'h79
`define EMR_SEG5_BEG        8'h9F
`define EMR_SEG5_END        8'hB9
// ****************************************************************
// Serial interface
// ****************************************************************
`define EMR_TGT_ADDR        7'h2A
`endif

// ### design/emr_top.v
// Energy monitor readout register bank behind a serial target port
`timescale 1ns/1ps
`include "emr_defs.vh"
module emr_top #(
  parameter [6:0] TARGET_ADDR = `EMR_TGT_ADDR
) (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire        scl_i,
  input  wire        sda_i,
  output wire        sda_o,
  output wire        sda_oe_o,
  input  wire [68:0] ch_energy_i,
  input  wire [2:0]  ch_update_i,
  input  wire [2:0]  ch_fault_i,
  input  wire [2:0]  ch_corrupt_i,
  input  wire [7:0]  therm_code_i,
  input  wire        therm_update_i,
  input  wire [7:0]  storage_code_i,
  input  wire        storage_update_i,
  input  wire [7:0]  source1_voltage_code_code_i,
  input  wire [7:0]  source2_voltage_code_code_i,
  input  wire [1:0]  src_update_i,
  input  wire        data_event_enable_i,
  input  wire        fault_event_enable_i,
  output wire [2:0]  monitor_enable_o,
  output reg         energy_data_ready_event_o,
  output reg         monitor_fault_event_o,
  output reg  [22:0] source1_voltage_code_microvolt_o,
  output reg  [22:0] source2_voltage_code_microvolt_o
);
  // ****************************************************************
  // Code helpers
  // ****************************************************************
  function code_valid;
    input [7:0] c;
    begin
      code_valid = (c <= `EMR_SEG3_END) ||
                   (c >= `EMR_SEG4_BEG && c <= `EMR_SEG4_END) ||
                   (c >= `EMR_SEG5_BEG && c <= `EMR_SEG5_END);
    end
  endfunction

  function [22:0] code_to_uv;
    input [7:0] c;
    integer ci;
    integer uv;
    begin
      ci = c;
      uv = 0;
      if (c <= `EMR_SEG1_END) begin
        uv = 113000;
      end else if (c <= `EMR_SEG2_END) begin
        uv = 90000 + (2 * ci - 9) * 7500;
      end else if (c <= `EMR_SEG3_END) begin
        uv = 300000 + (2 * ci - 37) * 15000;
      end else if (c >= `EMR_SEG4_BEG && c <= `EMR_SEG4_END) begin
        uv = ((300000 + (2 * ci - 165) * 15000) * 100) / 67;
      end else if (c >= `EMR_SEG5_BEG && c <= `EMR_SEG5_END) begin
        uv = ((300000 + (2 * ci - 293) * 15000) * 100) / 33;
      end
      code_to_uv = uv[22:0];
    end
  endfunction

  // ****************************************************************
  // Result registers
  // ****************************************************************
  reg [7:0]  config_reg;
  reg [22:0] energy [0:2];
  reg [5:0]  err_status;
  reg [7:0]  therm_code;
  reg [7:0]  storage_code;
  reg [7:0]  source1_voltage_code_code;
  reg [7:0]  source2_voltage_code_code;
  wire [2:0] ch_taken;
  integer    i;

  // ****************************************************************
  // Event causes
  // ****************************************************************
  // Faults and corrupt data share one event; the status byte tells them apart
  wire       data_cause;
  wire       fault_cause;

  assign data_cause  = (|ch_taken) & data_event_enable_i;
  assign fault_cause = (|(ch_taken & (ch_fault_i | ch_corrupt_i)))
                       & fault_event_enable_i;

  assign monitor_enable_o = config_reg[2:0];
  // One enable set gates every channel's result path
  assign ch_taken = ch_update_i & config_reg[2:0];

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (i = 0; i < `EMR_CHANNELS; i = i + 1) begin
        energy[i] <= {`EMR_ENERGY_W{1'b0}};
      end
      err_status                <= 6'h00;
      energy_data_ready_event_o <= 1'b0;
      monitor_fault_event_o     <= 1'b0;
    end else begin
      for (i = 0; i < `EMR_CHANNELS; i = i + 1) begin
        if (ch_taken[i]) begin
          energy[i]           <= ch_energy_i[i*23 +: 23];
          err_status[2*i]     <= ch_fault_i[i];
          err_status[2*i + 1] <= ch_corrupt_i[i];
        end
      end
      energy_data_ready_event_o <= data_cause;
      monitor_fault_event_o     <= fault_cause;
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      therm_code       <= `EMR_RESULT_RESET;
      storage_code     <= `EMR_RESULT_RESET;
      source1_voltage_code_code        <= `EMR_RESULT_RESET;
      source2_voltage_code_code        <= `EMR_RESULT_RESET;
      source1_voltage_code_microvolt_o <= 23'h000000;
      source2_voltage_code_microvolt_o <= 23'h000000;
    end else begin
      if (therm_update_i) begin
        therm_code <= therm_code_i;
      end
      if (storage_update_i) begin
        storage_code <= storage_code_i;
      end
      // Gap codes are dropped so the register never shows them
      if (src_update_i[0] && code_valid(source1_voltage_code_code_i)) begin
        source1_voltage_code_code <= source1_voltage_code_code_i;
      end
      if (src_update_i[1] && code_valid(source2_voltage_code_code_i)) begin
        source2_voltage_code_code <= source2_voltage_code_code_i;
      end
      source1_voltage_code_microvolt_o <= code_to_uv(source1_voltage_code_code);
      source2_voltage_code_microvolt_o <= code_to_uv(source2_voltage_code_code);
    end
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  reg [2:0] scl_sync;
  reg [2:0] sda_sync;
  reg       scl_f;
  reg       sda_f;
  reg       scl_prev;
  reg       sda_prev;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      scl_f    <= 1'b1;
      sda_f    <= 1'b1;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_i};
      sda_sync <= {sda_sync[1:0], sda_i};
      if (scl_sync[1] == scl_sync[2]) begin
        scl_f <= scl_sync[2];
      end
      if (sda_sync[1] == sda_sync[2]) begin
        sda_f <= sda_sync[2];
      end
      scl_prev <= scl_f;
      sda_prev <= sda_f;
    end
  end


  // ****************************************************************
  // Bus conditions
  // ****************************************************************
  // Edges come from filtered levels, so a short glitch never makes a bit
  wire scl_rise = scl_f & ~scl_prev;
  wire scl_fall = ~scl_f & scl_prev;
  wire bus_start = scl_f & scl_prev & sda_prev & ~sda_f;
  wire bus_stop  = scl_f & scl_prev & ~sda_prev & sda_f;

  // ****************************************************************
  // Read mux
  // ****************************************************************
  reg [7:0] pointer;
  reg [7:0] rd_data;

  always @* begin
    case (pointer)
      `EMR_OFS_CONFIG:     rd_data = config_reg;
      `EMR_OFS_SOURCE1_VOLTAGE_CODE_LOW:   rd_data = energy[0][7:0];
      `EMR_OFS_SOURCE1_VOLTAGE_CODE_MID:   rd_data = energy[0][15:8];
      `EMR_OFS_SOURCE1_VOLTAGE_CODE_HIGH:  rd_data = {1'b0, energy[0][22:16]};
      `EMR_OFS_SOURCE2_VOLTAGE_CODE_LOW:   rd_data = energy[1][7:0];
      `EMR_OFS_SOURCE2_VOLTAGE_CODE_MID:   rd_data = energy[1][15:8];
      `EMR_OFS_SOURCE2_VOLTAGE_CODE_HIGH:  rd_data = {1'b0, energy[1][22:16]};
      `EMR_OFS_OUT_LOW:    rd_data = energy[2][7:0];
      `EMR_OFS_OUT_MID:    rd_data = energy[2][15:8];
      `EMR_OFS_OUT_HIGH:   rd_data = {1'b0, energy[2][22:16]};
      `EMR_OFS_ERR_STATUS: rd_data = {2'b00, err_status};
      `EMR_OFS_THERM:      rd_data = therm_code;
      `EMR_OFS_STORAGE:    rd_data = storage_code;
      `EMR_OFS_SOURCE1_VOLTAGE_CODE_CODE:  rd_data = source1_voltage_code_code;
      `EMR_OFS_SOURCE2_VOLTAGE_CODE_CODE:  rd_data = source2_voltage_code_code;
      default:             rd_data = 8'h00;
    endcase
  end

  // ****************************************************************
  // Serial target state machine
  // ****************************************************************
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_ADDR  = 3'h1;
  localparam [2:0] ST_AACK  = 3'h2;
  localparam [2:0] ST_RX    = 3'h3;
  localparam [2:0] ST_RXACK = 3'h4;
  localparam [2:0] ST_TX    = 3'h5;
  localparam [2:0] ST_TXACK = 3'h6;

  reg [2:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] rx_shift;
  reg [7:0] tx_shift;
  reg       rw_read;
  reg       ptr_phase;
  reg       ack_drive;

  // Only a low is ever driven; the line idles released
  reg       pull_low;

  always @* begin
    pull_low = ack_drive;
    if (state == ST_TX) begin
      pull_low = ~tx_shift[7];
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_o = pull_low;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state      <= ST_IDLE;
      bit_cnt    <= 4'h0;
      rx_shift   <= 8'h00;
      tx_shift   <= 8'h00;
      rw_read    <= 1'b0;
      ptr_phase  <= 1'b0;
      ack_drive  <= 1'b0;
      pointer    <= 8'h00;
      config_reg <= `EMR_CFG_RESET;
    end else if (bus_start) begin
      state     <= ST_ADDR;
      bit_cnt   <= 4'h0;
      ack_drive <= 1'b0;
    end else if (bus_stop) begin
      state     <= ST_IDLE;
      ack_drive <= 1'b0;
    end else if (scl_rise) begin
      case (state)
        ST_ADDR, ST_RX: begin
          rx_shift <= {rx_shift[6:0], sda_f};
          bit_cnt  <= bit_cnt + 4'h1;
        end
        ST_TX: begin
          bit_cnt <= bit_cnt + 4'h1;
        end
        ST_AACK, ST_RXACK: begin
          // Acknowledge bits carry nothing for this target to keep
          state <= state;
        end
        ST_TXACK: begin
          // A not-acknowledge ends the read burst
          if (sda_f) begin
            state <= ST_IDLE;
          end else begin
            pointer <= pointer + 8'h01;
          end
        end
        default: begin
          state <= state;
        end
      endcase
    end else if (scl_fall) begin
      case (state)
        ST_ADDR: begin
          if (bit_cnt == 4'h8) begin
            if (rx_shift[7:1] == TARGET_ADDR) begin
              state     <= ST_AACK;
              rw_read   <= rx_shift[0];
              ack_drive <= 1'b1;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_AACK, ST_TXACK: begin
          ack_drive <= 1'b0;
          bit_cnt   <= 4'h0;
          if (state == ST_TXACK || rw_read) begin
            tx_shift <= rd_data;
            state    <= ST_TX;
          end else begin
            ptr_phase <= 1'b1;
            state     <= ST_RX;
          end
        end
        ST_RX: begin
          if (bit_cnt == 4'h8) begin
            ack_drive <= 1'b1;
            state     <= ST_RXACK;
            if (ptr_phase) begin
              pointer <= rx_shift;
            end else begin
              // Result registers take no writes
              if (pointer == `EMR_OFS_CONFIG) begin
                config_reg <= rx_shift & `EMR_CFG_WMASK;
              end
              pointer <= pointer + 8'h01;
            end
          end
        end
        ST_RXACK: begin
          ack_drive <= 1'b0;
          ptr_phase <= 1'b0;
          bit_cnt   <= 4'h0;
          state     <= ST_RX;
        end
        ST_TX: begin
          if (bit_cnt == 4'h8) begin
            state    <= ST_TXACK;
            tx_shift <= 8'hFF;
          end else begin
            tx_shift <= {tx_shift[6:0], 1'b1};
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// ### verif/emr_top_asserts.sv
// Concurrent checks on the energy monitor readout ports
`timescale 1ns/1ps
module emr_top_chk (
  input wire        clk_i,
  input wire        rst_n_i,
  input wire [2:0]  ch_update_i,
  input wire [2:0]  ch_fault_i,
  input wire [2:0]  ch_corrupt_i,
  input wire [7:0]  source1_voltage_code_code_i,
  input wire [7:0]  source2_voltage_code_code_i,
  input wire [1:0]  src_update_i,
  input wire        data_event_enable_i,
  input wire        fault_event_enable_i,
  input wire [2:0]  monitor_enable_o,
  input wire        energy_data_ready_event_o,
  input wire        monitor_fault_event_o,
  input wire [22:0] source1_voltage_code_microvolt_o,
  input wire [22:0] source2_voltage_code_microvolt_o
);
  wire taken;
  wire data_go;
  wire fault_go;
  wire gap1;
  assign taken = |(ch_update_i & monitor_enable_o);
  assign data_go = taken && data_event_enable_i;
  assign fault_go = fault_event_enable_i &&
                    |(ch_update_i & monitor_enable_o & (ch_fault_i | ch_corrupt_i));
  assign gap1 = (source1_voltage_code_code_i > 8'h39 && source1_voltage_code_code_i < 8'h68) ||
                (source1_voltage_code_code_i > 8'h79 && source1_voltage_code_code_i < 8'h9F) || source1_voltage_code_code_i > 8'hB9;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Code register first, then the decoded value
  sequence s_source1_voltage_code_load;
    src_update_i[0] ##2 1'b1;
  endsequence
  a_data_event: assert property (data_go |=> energy_data_ready_event_o)
    else $error("data event missing after taken update");
  a_data_quiet: assert property (!data_go |=> !energy_data_ready_event_o)
    else $error("data event without enabled update");
  a_fault_event: assert property (fault_go |=> monitor_fault_event_o)
    else $error("fault event missing");
  a_fault_quiet: assert property (!fault_go |=> !monitor_fault_event_o)
    else $error("fault event without cause");
  a_floor_code: assert property ((source1_voltage_code_code_i <= 8'h06) ##0 s_source1_voltage_code_load |-> source1_voltage_code_microvolt_o == 23'd113000)
    else $error("floor code decoded wrongly");
  a_fine_code: assert property (src_update_i[1] && source2_voltage_code_code_i == 8'h07 |-> ##2 source2_voltage_code_microvolt_o == 23'd127500)
    else $error("fine segment decoded wrongly");
  a_gap_ignored: assert property (src_update_i[0] && gap1 |=> $stable(source1_voltage_code_microvolt_o) [*2])
    else $error("gap code changed the source value");
  a_code_ceiling: assert property (source1_voltage_code_microvolt_o <= 23'd4409090 && source2_voltage_code_microvolt_o <= 23'd4409090)
    else $error("source value above the top code");
endmodule
bind emr_top emr_top_chk u_chk (.clk_i, .rst_n_i, .ch_update_i, .ch_fault_i, .ch_corrupt_i,
  .source1_voltage_code_code_i, .source2_voltage_code_code_i, .src_update_i, .data_event_enable_i, .fault_event_enable_i,
  .monitor_enable_o, .energy_data_ready_event_o, .monitor_fault_event_o, .source1_voltage_code_microvolt_o,
  .source2_voltage_code_microvolt_o);

// ### verif/emr_host.sv
// Behavioural serial host driving the register bus from the far side
`timescale 1ns/1ps
module emr_host (
  input  wire clk_i,
  input  wire sda_i,
  output reg  scl_o,
  output reg  sda_pull_o
);
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  task tick(input integer n);
    repeat (n) @(posedge clk_i);
  endtask
  // Half periods well above the target's pin filter delay
  task xfer(input b, output r);
    begin
      sda_pull_o <= ~b;
      tick(12);
      scl_o <= 1'b1;
      tick(12);
      r = sda_i;
      scl_o <= 1'b0;
      tick(4);
    end
  endtask
  task start;
    begin
      sda_pull_o <= 1'b0;
      tick(12);
      scl_o <= 1'b1;
      tick(12);
      sda_pull_o <= 1'b1;
      tick(12);
      scl_o <= 1'b0;
      tick(4);
    end
  endtask
  task stop;
    begin
      sda_pull_o <= 1'b1;
      tick(12);
      scl_o <= 1'b1;
      tick(12);
      sda_pull_o <= 1'b0;
      tick(12);
    end
  endtask
  task wbyte(input [7:0] d, output ack);
    integer i;
    reg     r;
    begin
      for (i = 7; i >= 0; i = i - 1)
        xfer(d[i], r);
      xfer(1'b1, r);
      ack = ~r;
    end
  endtask
  task rbyte(input last, output [7:0] d);
    integer i;
    reg     r;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        xfer(1'b1, r);
        d[i] = r;
      end
      xfer(last, r);
    end
  endtask
endmodule

// ### verif/energy_monitor_readout_test.sv
// Self-checking bench for the energy monitor readout
`timescale 1ns/1ps
`include "emr_defs.vh"
module energy_monitor_readout_test;
  reg         clk_i = 1'b0;
  reg         rst_n_i = 1'b0;
  reg  [68:0] ch_energy_i = 69'h0;
  reg  [2:0]  ch_update_i = 3'h0;
  reg  [2:0]  ch_fault_i = 3'h5;
  reg  [2:0]  ch_corrupt_i = 3'h2;
  reg  [7:0]  therm_code_i = 8'hC8;
  reg         therm_update_i = 1'b0;
  reg  [7:0]  storage_code_i = 8'h5A;
  reg         storage_update_i = 1'b0;
  reg  [7:0]  source1_voltage_code_code_i = 8'h39;
  reg  [7:0]  source2_voltage_code_code_i = 8'h9F;
  reg  [1:0]  src_update_i = 2'h0;
  reg         data_event_enable_i = 1'b1;
  reg         fault_event_enable_i = 1'b1;
  wire        scl_i, sda_i, sda_o, sda_oe_o, host_pull;
  wire [2:0]  monitor_enable_o;
  wire        energy_data_ready_event_o, monitor_fault_event_o;
  wire [22:0] source1_voltage_code_microvolt_o, source2_voltage_code_microvolt_o;
  integer     failures = 0;
  integer     compares = 0;
  integer     i;
  reg  [7:0]  rd;
  reg         ack;
  // Rows of offset and expected byte after the load below
  localparam [255:0] ROWS = {16'h110F, 16'h193B, 16'h1A5C, 16'h1B6A, 16'h1C45, 16'h1D23,
    16'h1E01, 16'h1FFF, 16'h20FF, 16'h217F, 16'h2219, 16'h23C8, 16'h245A, 16'h2539,
    16'h269F, 16'h2700};
  assign sda_i = ~(sda_oe_o | host_pull);
  emr_top DUT (.clk_i, .rst_n_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .ch_energy_i,
    .ch_update_i, .ch_fault_i, .ch_corrupt_i, .therm_code_i, .therm_update_i,
    .storage_code_i, .storage_update_i, .source1_voltage_code_code_i, .source2_voltage_code_code_i, .src_update_i,
    .data_event_enable_i, .fault_event_enable_i, .monitor_enable_o,
    .energy_data_ready_event_o, .monitor_fault_event_o, .source1_voltage_code_microvolt_o, .source2_voltage_code_microvolt_o);
  emr_host h (.clk_i(clk_i), .sda_i(sda_i), .scl_o(scl_i), .sda_pull_o(host_pull));
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  task chk8(input string nm, input [7:0] e, input [7:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("CHECK FAILED %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task chk23(input string nm, input [22:0] e, input [22:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("CHECK FAILED %0s expected %0d seen %0d", nm, e, g);
      end
    end
  endtask
  task reg_wr(input [7:0] a, input [7:0] d);
    begin
      h.start;
      h.wbyte({`EMR_TGT_ADDR, 1'b0}, ack);
      h.wbyte(a, ack);
      h.wbyte(d, ack);
      h.stop;
    end
  endtask
  task reg_rd(input [7:0] a, output [7:0] d);
    begin
      h.start;
      h.wbyte({`EMR_TGT_ADDR, 1'b0}, ack);
      h.wbyte(a, ack);
      h.start;
      h.wbyte({`EMR_TGT_ADDR, 1'b1}, ack);
      h.rbyte(1'b1, d);
      h.stop;
    end
  endtask
  task pulse(input [2:0] u, input t, input [1:0] s);
    begin
      @(posedge clk_i);
      ch_update_i <= u;
      therm_update_i <= t;
      storage_update_i <= t;
      src_update_i <= s;
      @(posedge clk_i);
      ch_update_i <= 3'h0;
      therm_update_i <= 1'b0;
      storage_update_i <= 1'b0;
      src_update_i <= 2'h0;
      repeat (3) @(posedge clk_i);
      #1;
    end
  endtask
  task close_out;
    begin
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    #240000;
    failures = failures + 1;
    close_out;
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    reg_rd(8'h11, rd);
    chk8("cfg reset", 8'h00, rd);
    reg_wr(8'h11, 8'hFF);
    reg_rd(8'h11, rd);
    chk8("cfg upper bits", 8'h1F, rd);
    reg_wr(8'h11, 8'h0F);
    chk8("enables", 8'h07, {5'h0, monitor_enable_o});
    ch_energy_i <= {23'h7FFFFF, 23'h012345, 23'h6A5C3B};
    pulse(3'h7, 1'b1, 2'h3);
    for (i = 0; i < 16; i = i + 1) begin
      reg_rd(ROWS[i*16+8 +: 8], rd);
      chk8("row", ROWS[i*16 +: 8], rd);
    end
    chk23("source1_voltage_code value", 23'd1455000, source1_voltage_code_microvolt_o);
    chk23("source2_voltage_code value", 23'd2045454, source2_voltage_code_microvolt_o);
    reg_wr(8'h25, 8'h00);
    reg_rd(8'h25, rd);
    chk8("result write", 8'h39, rd);
    source1_voltage_code_code_i <= 8'h50;
    source2_voltage_code_code_i <= 8'hBA;
    pulse(3'h0, 1'b0, 2'h3);
    reg_rd(8'h26, rd);
    chk8("gap code", 8'h9F, rd);
    source1_voltage_code_code_i <= 8'h06;
    source2_voltage_code_code_i <= 8'h07;
    pulse(3'h0, 1'b0, 2'h3);
    chk23("floor", 23'd113000, source1_voltage_code_microvolt_o);
    chk23("fine", 23'd127500, source2_voltage_code_microvolt_o);
    source1_voltage_code_code_i <= 8'h12;
    source2_voltage_code_code_i <= 8'hB9;
    pulse(3'h0, 1'b0, 2'h3);
    chk23("fine top", 23'd292500, source1_voltage_code_microvolt_o);
    chk23("top code", 23'd4409090, source2_voltage_code_microvolt_o);
    reg_wr(8'h11, 8'h0E);
    fault_event_enable_i <= 1'b0;
    ch_energy_i <= 69'h0;
    pulse(3'h1, 1'b0, 2'h0);
    reg_rd(8'h19, rd);
    chk8("disabled channel", 8'h3B, rd);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    reg_rd(8'h1B, rd);
    chk8("energy reset", 8'h00, rd);
    close_out;
  end
endmodule
